/* File: hw/digitizer_cfg.svh */
/*
 Constants of the digitizer control block: register select codes,
 command field positions, sync source codes and reset values.
 Assumes inclusion by bare name from the design file.
*/
`ifndef DIGITIZER_CFG_SVH
`define DIGITIZER_CFG_SVH
`define LVL_COUNT 6
`define SEL_CMD 3'h6
`define CMD_DIG_BIT 7
`define CMD_SRC_HI 6
`define CMD_SRC_LO 4
`define CMD_MODE_HI 3
`define CMD_MODE_LO 2
`define CMD_LVL_BIT 0
`define CMD_RESET 8'h00
`define SRC_EXT_FIRST 3'h6
`define SRC_EXT_SECOND 3'h7
`define SAMPLE_RESET 8'h00
`define CHAN_COUNT 3
`endif

/* File: hw/digitizer_pkg.sv */
/*
 Types of the digitizer control block.
 Assumes nothing of its surroundings.
*/
package digitizer_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {
        MODE_24,
        MODE_15,
        MODE_8T,
        MODE_8P
    } pack_mode_e;
endpackage

/* File: hw/digitizer_ctl.sv */
/*
 Digital control side of a three-channel video digitizer: host port with
 six level registers and a command register, per-channel sample output
 registers, zeroing hold, output enables, clamp and sync source select.
 Assumes all inputs, the channel clocks and the host strobes among them,
 are synchronous to clk_i and held for at least one clk_i cycle.
*/
`timescale 1ns/1ns
`include "digitizer_cfg.svh"
module digitizer_ctl #(
    parameter int LVL_N = `LVL_COUNT
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Host port
    input wire logic [2:0] host_register_select_i,
    input wire logic host_rd_n_i,
    input wire logic host_wr_n_i,
    input wire logic [7:0] host_data_bus_i,
    output logic [7:0] host_data_bus_o,
    output logic host_data_bus_oe_n_o,
    // Current level outputs
    output logic [LVL_N-1:0][7:0] dac_current_outputs_o,
    // Channel clocks and conversion results
    input wire logic red_sample_clock_i,
    input wire logic green_sample_clock_i,
    input wire logic blue_sample_clock_i,
    input wire logic [7:0] red_adc_result_i,
    input wire logic [7:0] green_adc_result_i,
    input wire logic [7:0] blue_adc_result_i,
    input wire logic zero_i,
    output logic [2:0] comparators_zeroed_o,
    // Sample output buses
    input wire logic sample_oe_n_i,
    output logic [7:0] red_sample_bus_o,
    output logic red_sample_bus_oe_n_o,
    output logic [7:0] green_sample_bus_o,
    output logic green_sample_bus_oe_n_o,
    output logic [7:0] blue_sample_bus_o,
    output logic blue_sample_bus_oe_n_o,
    // Analog steering
    input wire logic clamp_i,
    output logic clamp_restore_o,
    output logic digitize_select_o,
    output logic sync_level_select_o,
    // Sync
    input wire logic [5:0] video_sync_slice_n_i,
    input wire logic external_sync_in_first_n_i,
    input wire logic external_sync_in_second_n_i,
    output logic composite_sync_out_n_o
);

    function automatic logic [7:0] pack(input logic [1:0] m, input int c,
                                        input logic [7:0] r, input logic [7:0] g, input logic [7:0] b);
        case (digitizer_pkg::pack_mode_e'(m))
            digitizer_pkg::MODE_24: pack = (c == 0) ? r : ((c == 1) ? g : b);
            digitizer_pkg::MODE_15: pack = (c == 0) ? {1'b0, r[7:3], g[7:6]} :
                                           ((c == 1) ? {g[5:3], b[7:3]} : 8'h00);
            digitizer_pkg::MODE_8T: pack = {r[7:5], g[7:5], b[7:6]};
            default: pack = g;
        endcase
    endfunction

    logic rd_n_q_ff;
    logic wr_n_q_ff;
    logic [2:0] sel_ff;
    digitizer_pkg::byte_t wdata_ff;
    digitizer_pkg::byte_t cmd_ff;
    logic [LVL_N-1:0][7:0] level_ff;
    digitizer_pkg::byte_t rd_val;
    logic [2:0] cur_sel;
    logic rd_fall;
    logic wr_fall;
    logic wr_rise;

    assign rd_fall = rd_n_q_ff & ~host_rd_n_i;
    assign wr_fall = wr_n_q_ff & ~host_wr_n_i;
    assign wr_rise = ~wr_n_q_ff & host_wr_n_i;
    assign cur_sel = rd_fall ? host_register_select_i : sel_ff;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rd_n_q_ff <= 1'b1;
            wr_n_q_ff <= 1'b1;
        end else begin
            rd_n_q_ff <= host_rd_n_i;
            wr_n_q_ff <= host_wr_n_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sel_ff <= 3'h0;
        end else if (rd_fall || wr_fall) begin
            sel_ff <= host_register_select_i;
        end
    end

    // Data is kept while the strobe is low so the rising edge writes the last bus value
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wdata_ff <= 8'h00;
        end else if (!host_wr_n_i) begin
            wdata_ff <= host_data_bus_i;
        end
    end

    // Levels carry no reset on purpose: software must load them
    always_ff @(posedge clk_i) begin
        if (wr_rise && (int'(sel_ff) < LVL_N)) begin
            level_ff[sel_ff] <= wdata_ff;
        end
    end

    assign dac_current_outputs_o = level_ff;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cmd_ff <= `CMD_RESET;
        end else if (wr_rise && (sel_ff == `SEL_CMD)) begin
            cmd_ff <= wdata_ff;
        end
    end

    always_comb begin
        rd_val = 8'h00;
        if (int'(cur_sel) < LVL_N) begin
            rd_val = level_ff[cur_sel];
        end else if (cur_sel == `SEL_CMD) begin
            rd_val = cmd_ff;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            host_data_bus_o <= 8'h00;
            host_data_bus_oe_n_o <= 1'b1;
        end else begin
            host_data_bus_oe_n_o <= host_rd_n_i;
            if (!host_rd_n_i) begin
                host_data_bus_o <= rd_val;
            end
        end
    end

    logic [2:0] chclk_q_ff;
    logic [2:0] chrise;
    logic [2:0][7:0] adc;
    logic [2:0][7:0] raw_ff;
    logic [2:0][7:0] bus_ff;
    logic [1:0] mode;

    assign adc = {blue_adc_result_i, green_adc_result_i, red_adc_result_i};
    assign chrise = {blue_sample_clock_i, green_sample_clock_i, red_sample_clock_i} & ~chclk_q_ff;
    assign mode = cmd_ff[`CMD_MODE_HI:`CMD_MODE_LO];

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            chclk_q_ff <= 3'h7;
            comparators_zeroed_o <= 3'h0;
        end else begin
            chclk_q_ff <= {blue_sample_clock_i, green_sample_clock_i, red_sample_clock_i};
            for (int c = 0; c < `CHAN_COUNT; c++) begin
                if (chrise[c]) begin
                    comparators_zeroed_o[c] <= zero_i;
                end
            end
        end
    end

    // Channels clocked in the same cycle share their new samples; the rest give their last held one,
    // so tied clocks never leave a packed bus one sample behind
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            raw_ff <= {3{`SAMPLE_RESET}};
            bus_ff <= {3{`SAMPLE_RESET}};
        end else begin
            for (int c = 0; c < `CHAN_COUNT; c++) begin
                if (chrise[c] && !zero_i) begin
                    raw_ff[c] <= adc[c];
                    bus_ff[c] <= pack(mode, c, chrise[0] ? adc[0] : raw_ff[0],
                                      chrise[1] ? adc[1] : raw_ff[1],
                                      chrise[2] ? adc[2] : raw_ff[2]);
                end
            end
        end
    end

    assign red_sample_bus_o = bus_ff[0];
    assign green_sample_bus_o = bus_ff[1];
    assign blue_sample_bus_o = bus_ff[2];

    // Enables, clamp and sync bypass the clock: they must act without delay
    assign red_sample_bus_oe_n_o = sample_oe_n_i;
    assign green_sample_bus_oe_n_o = sample_oe_n_i;
    assign blue_sample_bus_oe_n_o = sample_oe_n_i;
    assign clamp_restore_o = clamp_i;
    assign digitize_select_o = cmd_ff[`CMD_DIG_BIT];
    assign sync_level_select_o = cmd_ff[`CMD_LVL_BIT];

    logic [2:0] src;
    assign src = cmd_ff[`CMD_SRC_HI:`CMD_SRC_LO];

    always_comb begin
        case (src)
            `SRC_EXT_FIRST: composite_sync_out_n_o = external_sync_in_first_n_i;
            `SRC_EXT_SECOND: composite_sync_out_n_o = external_sync_in_second_n_i;
            default: composite_sync_out_n_o = video_sync_slice_n_i[src];
        endcase
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    property p_zero_hold;
        chrise[0] && zero_i |=> red_sample_bus_o == $past(red_sample_bus_o);
    endproperty
    a_zero_hold: assert property (p_zero_hold) else $error("red bus moved while zeroing");

    property p_update;
        chrise[1] && !zero_i && mode == 2'h0 |=> green_sample_bus_o == $past(green_adc_result_i);
    endproperty
    a_update: assert property (p_update) else $error("green bus not updated on its edge");

    property p_zero_latch;
        chrise[2] |=> comparators_zeroed_o[2] == $past(zero_i);
    endproperty
    a_zero_latch: assert property (p_zero_latch) else $error("blue zeroing not latched");

    property p_oe;
        red_sample_bus_oe_n_o == sample_oe_n_i && green_sample_bus_oe_n_o == sample_oe_n_i
            && blue_sample_bus_oe_n_o == sample_oe_n_i;
    endproperty
    a_oe: assert property (p_oe) else $error("sample bus driven while disabled");

    property p_rd_oe;
        !host_rd_n_i ##1 !host_rd_n_i |-> !host_data_bus_oe_n_o ##1 1'b1;
    endproperty
    a_rd_oe: assert property (p_rd_oe) else $error("host bus not driven during read");

    property p_rd_off;
        host_rd_n_i ##1 host_rd_n_i |-> host_data_bus_oe_n_o;
    endproperty
    a_rd_off: assert property (p_rd_off) else $error("host bus driven outside read");

    property p_write;
        wr_rise && sel_ff < 3'h6 |=> level_ff[$past(sel_ff)] == $past(wdata_ff);
    endproperty
    a_write: assert property (p_write) else $error("level write lost");

    property p_sel_hold;
        !host_rd_n_i && !rd_fall |=> $stable(sel_ff);
    endproperty
    a_sel_hold: assert property (p_sel_hold) else $error("select changed mid read");

    property p_ext_sync;
        src == `SRC_EXT_SECOND |-> composite_sync_out_n_o == external_sync_in_second_n_i;
    endproperty
    a_ext_sync: assert property (p_ext_sync) else $error("second external sync not routed");

    property p_mode11;
        chrise[0] && chrise[1] && !zero_i && mode == 2'h3 |=> red_sample_bus_o == $past(green_adc_result_i);
    endproperty
    a_mode11: assert property (p_mode11) else $error("mode 11 not green only");

    property p_readback;
        rd_fall && host_register_select_i < 3'h6 && host_wr_n_i
            |=> host_data_bus_o == level_ff[$past(host_register_select_i)];
    endproperty
    a_readback: assert property (p_readback) else $error("level readback wrong");

    property p_unmapped;
        rd_fall && host_register_select_i == 3'h7 |=> host_data_bus_o == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped select read nonzero");

    property p_cmd_hold;
        !(wr_rise && sel_ff == `SEL_CMD) |=> $stable(cmd_ff);
    endproperty
    a_cmd_hold: assert property (p_cmd_hold) else $error("command changed without a write");

    property p_cs_video;
        src < `SRC_EXT_FIRST |-> composite_sync_out_n_o == video_sync_slice_n_i[src];
    endproperty
    a_cs_video: assert property (p_cs_video) else $error("video sync source not routed");

    c_write: cover property (wr_rise && sel_ff == 3'h2);
    c_read: cover property (rd_fall ##[1:8] !host_data_bus_oe_n_o);
    c_zero: cover property (chrise[0] && zero_i);
    c_mode11: cover property (chrise[0] && chrise[1] && !zero_i && mode == 2'h3);
    c_sync_ext: cover property (src == `SRC_EXT_FIRST);
endmodule

/* File: dv/host_mpu_model.sv */
/*
 Host processor model for the byte-wide register port.
 Assumes the strobes are sampled on rising clk_i edges.
*/
`timescale 1ns/1ns
module host_mpu_model (
    // Clock
    input wire logic clk_i,
    // Device side
    input wire logic [7:0] data_i,
    input wire logic oe_n_i,
    output logic [2:0] sel_o,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic [7:0] data_o
);
    initial begin
        sel_o = 3'h0;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        data_o = 8'hFF;
    end
    // Only one strobe is ever low; s_late moves the select after the fall
    task automatic wr(input logic [2:0] s, input logic [7:0] d, input logic [2:0] s_late);
        @(negedge clk_i);
        sel_o = s;
        data_o = d;
        wr_n_o = 1'b0;
        @(negedge clk_i);
        sel_o = s_late;
        wr_n_o = 1'b1;
        @(negedge clk_i);
        // Released bus shows the inverse so stale data cannot pass
        data_o = ~d;
        @(negedge clk_i);
    endtask
    task automatic rd(input logic [2:0] s, output logic [7:0] q);
        int n;
        n = 0;
        @(negedge clk_i);
        sel_o = s;
        rd_n_o = 1'b0;
        do begin
            @(negedge clk_i);
            n++;
        end while (oe_n_i !== 1'b0 && n < 4);
        // Select moves after the fall; the captured one must still be read
        sel_o = ~s;
        @(negedge clk_i);
        q = (oe_n_i === 1'b0) ? data_i : 8'hXX;
        rd_n_o = 1'b1;
        @(negedge clk_i);
    endtask
endmodule

/* File: dv/test_digitizer_ctl.sv */
/*
 Self-checking bench of the digitizer control block.
 Assumes the host model drives the register port.
*/
`timescale 1ns/1ns
module test_digitizer_ctl;
    logic clk_i, rst_n_i, rd_n, wr_n, d_oe_n, rc, gc, bc, zero, s_oe_n, clamp, clr, dsel, lsel, x0, x1, cs;
    logic [2:0] sel, zd, boe;
    logic [7:0] d_in, d_out, ra, ga, ba, rb, gb, bb, q;
    logic [5:0] sl;
    logic [5:0][7:0] lvl;
    logic [23:0] pk [4] = '{24'h123456, 24'h08CA00, 24'h050505, 24'h343434};
    int fail_count = 0;
    int compares = 0;
    digitizer_ctl i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .host_register_select_i(sel),
        .host_rd_n_i(rd_n), .host_wr_n_i(wr_n), .host_data_bus_i(d_in), .host_data_bus_o(d_out),
        .host_data_bus_oe_n_o(d_oe_n), .dac_current_outputs_o(lvl), .red_sample_clock_i(rc),
        .green_sample_clock_i(gc), .blue_sample_clock_i(bc), .red_adc_result_i(ra),
        .green_adc_result_i(ga), .blue_adc_result_i(ba), .zero_i(zero), .comparators_zeroed_o(zd),
        .sample_oe_n_i(s_oe_n), .red_sample_bus_o(rb), .red_sample_bus_oe_n_o(boe[0]),
        .green_sample_bus_o(gb), .green_sample_bus_oe_n_o(boe[1]), .blue_sample_bus_o(bb),
        .blue_sample_bus_oe_n_o(boe[2]), .clamp_i(clamp), .clamp_restore_o(clr),
        .digitize_select_o(dsel), .sync_level_select_o(lsel), .video_sync_slice_n_i(sl),
        .external_sync_in_first_n_i(x0), .external_sync_in_second_n_i(x1),
        .composite_sync_out_n_o(cs));
    host_mpu_model i_host (.clk_i(clk_i), .data_i(d_out), .oe_n_i(d_oe_n), .sel_o(sel),
        .rd_n_o(rd_n), .wr_n_o(wr_n), .data_o(d_in));
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        chk8({7'h0, g}, {7'h0, e});
    endtask
    task automatic final_report;
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // All three channel clocks rise together, then fall
    task automatic pulse;
        @(negedge clk_i);
        {rc, gc, bc} = 3'h7;
        repeat (2) @(negedge clk_i);
        {rc, gc, bc} = 3'h0;
        @(negedge clk_i);
    endtask
    function automatic logic [7:0] lv(input int k);
        return 8'hC3 ^ 8'(k << 2);
    endfunction
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    // Whole run is near 1200 cycles; this is about twenty times that
    initial begin
        #100000;
        fail_count++;
        final_report;
    end
    initial begin
        rst_n_i = 1'b0;
        {rc, gc, bc, zero, s_oe_n, clamp} = 6'h00;
        {x0, x1, sl} = 8'hFF;
        {ra, ga, ba} = 24'hA53C81;
        repeat (4) @(negedge clk_i);
        rst_n_i = 1'b1;
        chk1(d_oe_n, 1'b1);
        zero = 1'b1;
        repeat (250) pulse;
        chk8(rb, 8'h00);
        chk8({5'h0, zd}, 8'h07);
        zero = 1'b0;
        pulse;
        chk8(rb, 8'hA5);
        chk8(gb, 8'h3C);
        chk8(bb, 8'h81);
        chk8({5'h0, zd}, 8'h00);
        zero = 1'b1;
        ra = 8'h11;
        pulse;
        chk8(rb, 8'hA5);
        zero = 1'b0;
        s_oe_n = 1'b1;
        clamp = 1'b1;
        #1;
        chk8({5'h0, boe}, 8'h07);
        chk1(clr, 1'b1);
        s_oe_n = 1'b0;
        clamp = 1'b0;
        #1;
        chk8({5'h0, boe}, 8'h00);
        chk1(clr, 1'b0);
        for (int k = 0; k < 6; k++) i_host.wr(3'(k), lv(k), 3'(k));
        for (int k = 0; k < 6; k++) begin
            chk8(lvl[k], lv(k));
            i_host.rd(3'(k), q);
            chk8(q, lv(k));
        end
        i_host.wr(3'h2, 8'h7E, 3'h3);
        i_host.rd(3'h3, q);
        chk8(q, lv(3));
        i_host.rd(3'h2, q);
        chk8(q, 8'h7E);
        i_host.rd(3'h7, q);
        chk8(q, 8'h00);
        @(negedge clk_i);
        chk1(d_oe_n, 1'b1);
        for (int c = 0; c < 8; c++) begin
            sl = ~(6'h01 << c);
            x0 = (c != 6);
            x1 = (c != 7);
            i_host.wr(3'h6, {1'b0, 3'(c), 4'h0}, 3'h6);
            chk1(cs, 1'b0);
            {sl, x0, x1} = ~{sl, x0, x1};
            #1;
            chk1(cs, 1'b1);
        end
        i_host.wr(3'h6, 8'h81, 3'h6);
        chk1(dsel, 1'b1);
        chk1(lsel, 1'b1);
        {ra, ga, ba} = 24'h123456;
        for (int m = 0; m < 4; m++) begin
            i_host.wr(3'h6, {4'h0, 2'(m), 2'h0}, 3'h6);
            repeat (2) pulse;
            chk8(rb, pk[m][23:16]);
            chk8(gb, pk[m][15:8]);
            chk8(bb, pk[m][7:0]);
        end
        chk1(dsel, 1'b0);
        chk1(lsel, 1'b0);
        final_report;
    end
endmodule
